/* sbst_pkg.sv */
// constants shared by the boundary-scan test access port
// assumes a 16-state tap machine and a 3-bit instruction register
package sbst_pkg;

  // ==========================================================
  // instruction codes
  localparam logic [2:0] SBST_IR_EXTEST   = 3'h0;
  localparam logic [2:0] SBST_IR_IDCODE   = 3'h1;
  localparam logic [2:0] SBST_IR_SAMPLEZ  = 3'h2;
  localparam logic [2:0] SBST_IR_SAMPLE   = 3'h4;
  localparam logic [2:0] SBST_IR_BYPASS   = 3'h7;
  localparam int         SBST_IR_LEN      = 3;
  // capture-ir pattern, two low bits 01
  localparam logic [2:0] SBST_IR_CAPTURE  = 3'h1;

  // ==========================================================
  // register sizes and reset values
  localparam int         SBST_BSR_LEN     = 109;
  // output-enable cell, numbered 109 counted from one
  localparam int         SBST_OE_CELL     = 108;
  localparam int         SBST_ID_LEN      = 32;
  localparam logic       SBST_OE_CELL_RST = 1'h0;
  localparam logic       SBST_BYP_RST     = 1'h0;
  // consecutive high mode-select edges that force reset
  localparam int         SBST_TMS_RST_EDGES = 5;

  // ==========================================================
  // tap states, one-hot
  typedef enum logic [15:0] {
    SBST_TLR  = 16'h0001,
    SBST_RTI  = 16'h0002,
    SBST_SDRS = 16'h0004,
    SBST_CDR  = 16'h0008,
    SBST_SDR  = 16'h0010,
    SBST_E1DR = 16'h0020,
    SBST_PDR  = 16'h0040,
    SBST_E2DR = 16'h0080,
    SBST_UDR  = 16'h0100,
    SBST_SIRS = 16'h0200,
    SBST_CIR  = 16'h0400,
    SBST_SIR  = 16'h0800,
    SBST_E1IR = 16'h1000,
    SBST_PIR  = 16'h2000,
    SBST_E2IR = 16'h4000,
    SBST_UIR  = 16'h8000
  } sbst_state_type;

  typedef enum logic [2:0] {
    SBST_SEL_BSR = 3'h1,
    SBST_SEL_ID  = 3'h2,
    SBST_SEL_BYP = 3'h4
  } sbst_sel_type;

endpackage

/* sbst_sync2.sv */
// two-flop level synchroniser, any width
// assumes each bit is a slow level or quasi-static word
`timescale 1ns/1ps
`default_nettype none

module sbst_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  initial
  begin
    if (W < 1)
      $error("sbst_sync2: width must be at least one");
  end

  // no reset: the second flop alone feeds downstream logic
  always_ff @(posedge clk)
  begin
    meta_r <= d;
    q      <= meta_r;
  end

endmodule

`default_nettype wire

/* sbst_tap.sv */
// boundary-scan test access port of a synchronous memory
// assumes tck runs the scan logic and core_clk the memory ring;
// ring values cross by two-flop synchronisers, updated outputs are static
`timescale 1ns/1ps
`default_nettype none

module sbst_tap
  import sbst_pkg::*;
#(
  parameter int          BSR_LEN = sbst_pkg::SBST_BSR_LEN,
  // arbitrary identification value; bit 0 must stay one
  parameter logic [31:0] ID_CODE = 32'h0000_0a5b
) (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic               test_clk,
  input  wire logic               test_mode_sel,
  input  wire logic               test_data_in,
  output var  logic               test_data_out,
  output var  logic               test_data_out_oe,
  input  wire logic [BSR_LEN-2:0] ring_in,
  output var  logic [BSR_LEN-2:0] ring_out,
  output var  logic               ring_drive_en,
  output var  logic               q_bus_hiz
);

  import sbst_pkg::*;

  initial
  begin
    if (BSR_LEN != SBST_OE_CELL + 1)
      $error("sbst_tap: output-enable cell must be the last boundary cell");
    if (ID_CODE[0] != 1'b1)
      $error("sbst_tap: identification start bit must be one");
  end

  // ==========================================================
  // crossings into the test clock domain
  logic               tck_rst;
  logic [BSR_LEN-2:0] ring_in_s;

  sbst_sync2 #(.W(1)) u_rst_sync (
    .clk (test_clk),
    .d   (sys_rst),
    .q   (tck_rst)
  );

  sbst_sync2 #(.W(BSR_LEN-1)) u_ring_sync (
    .clk (test_clk),
    .d   (ring_in),
    .q   (ring_in_s)
  );

  // ==========================================================
  // tap state machine
  sbst_state_type state_r;
  sbst_state_type state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SBST_TLR:  state_nxt = test_mode_sel ? SBST_TLR  : SBST_RTI;
      SBST_RTI:  state_nxt = test_mode_sel ? SBST_SDRS : SBST_RTI;
      SBST_SDRS: state_nxt = test_mode_sel ? SBST_SIRS : SBST_CDR;
      SBST_CDR:  state_nxt = test_mode_sel ? SBST_E1DR : SBST_SDR;
      SBST_SDR:  state_nxt = test_mode_sel ? SBST_E1DR : SBST_SDR;
      SBST_E1DR: state_nxt = test_mode_sel ? SBST_UDR  : SBST_PDR;
      SBST_PDR:  state_nxt = test_mode_sel ? SBST_E2DR : SBST_PDR;
      SBST_E2DR: state_nxt = test_mode_sel ? SBST_UDR  : SBST_SDR;
      SBST_UDR:  state_nxt = test_mode_sel ? SBST_SDRS : SBST_RTI;
      SBST_SIRS: state_nxt = test_mode_sel ? SBST_TLR  : SBST_CIR;
      SBST_CIR:  state_nxt = test_mode_sel ? SBST_E1IR : SBST_SIR;
      SBST_SIR:  state_nxt = test_mode_sel ? SBST_E1IR : SBST_SIR;
      SBST_E1IR: state_nxt = test_mode_sel ? SBST_UIR  : SBST_PIR;
      SBST_PIR:  state_nxt = test_mode_sel ? SBST_E2IR : SBST_PIR;
      SBST_E2IR: state_nxt = test_mode_sel ? SBST_UIR  : SBST_SIR;
      SBST_UIR:  state_nxt = test_mode_sel ? SBST_SDRS : SBST_RTI;
      default:   state_nxt = SBST_TLR;
    endcase
  end

  always_ff @(posedge test_clk)
  begin
    if (tck_rst)
      state_r <= SBST_TLR;
    else
      state_r <= state_nxt;
  end

  // ==========================================================
  // instruction register and decode
  logic [2:0]   ir_sh_r;
  logic [2:0]   ir_sh_nxt;
  logic [2:0]   ir_r;
  logic [2:0]   ir_nxt;
  sbst_sel_type sel;

  always_comb
  begin
    // reserved codes fall through to bypass
    if (ir_r == SBST_IR_EXTEST || ir_r == SBST_IR_SAMPLEZ || ir_r == SBST_IR_SAMPLE)
      sel = SBST_SEL_BSR;
    else if (ir_r == SBST_IR_IDCODE)
      sel = SBST_SEL_ID;
    else
      sel = SBST_SEL_BYP;
  end

  always_comb
  begin
    ir_sh_nxt = ir_sh_r;
    ir_nxt    = ir_r;
    case (state_r)
      SBST_TLR: ir_nxt = SBST_IR_IDCODE;
      SBST_CIR: ir_sh_nxt = SBST_IR_CAPTURE;
      SBST_SIR: ir_sh_nxt = {test_data_in, ir_sh_r[2:1]};
      SBST_UIR: ir_nxt = ir_sh_r;
      default:  ir_nxt = ir_r;
    endcase
  end

  always_ff @(posedge test_clk)
  begin
    if (tck_rst)
    begin
      ir_sh_r <= SBST_IR_IDCODE;
      ir_r    <= SBST_IR_IDCODE;
    end
    else
    begin
      ir_sh_r <= ir_sh_nxt;
      ir_r    <= ir_nxt;
    end
  end

  // ==========================================================
  // data registers
  logic               byp_r;
  logic               byp_nxt;
  logic [31:0]        id_sh_r;
  logic [31:0]        id_sh_nxt;
  logic [BSR_LEN-1:0] bsr_sh_r;
  logic [BSR_LEN-1:0] bsr_sh_nxt;
  logic [BSR_LEN-1:0] bsr_upd_r;
  logic [BSR_LEN-1:0] bsr_upd_nxt;

  always_comb
  begin
    byp_nxt     = byp_r;
    id_sh_nxt   = id_sh_r;
    bsr_sh_nxt  = bsr_sh_r;
    bsr_upd_nxt = bsr_upd_r;
    if (state_r == SBST_TLR)
      bsr_upd_nxt[SBST_OE_CELL] = SBST_OE_CELL_RST;
    else if (state_r == SBST_CDR)
    begin
      byp_nxt    = SBST_BYP_RST;
      id_sh_nxt  = ID_CODE;
      // oe cell reads back its own latched value
      bsr_sh_nxt = {bsr_upd_r[SBST_OE_CELL], ring_in_s};
    end
    else if (state_r == SBST_SDR)
    begin
      // only the selected register moves
      if (sel == SBST_SEL_BYP)
        byp_nxt = test_data_in;
      else if (sel == SBST_SEL_ID)
        id_sh_nxt = {test_data_in, id_sh_r[31:1]};
      else
        bsr_sh_nxt = {test_data_in, bsr_sh_r[BSR_LEN-1:1]};
    end
    else if (state_r == SBST_UDR && sel == SBST_SEL_BSR)
      bsr_upd_nxt = bsr_sh_r;
  end

  always_ff @(posedge test_clk)
  begin
    if (tck_rst)
    begin
      byp_r     <= SBST_BYP_RST;
      id_sh_r   <= '0;
      bsr_sh_r  <= '0;
      bsr_upd_r <= '0;
    end
    else
    begin
      byp_r     <= byp_nxt;
      id_sh_r   <= id_sh_nxt;
      bsr_sh_r  <= bsr_sh_nxt;
      bsr_upd_r <= bsr_upd_nxt;
    end
  end

  // ==========================================================
  // serial output on the falling edge
  logic tdo_nxt;
  logic tdo_oe_nxt;
  logic tdo_oe_r;

  always_comb
  begin
    tdo_oe_nxt = (state_r == SBST_SIR) || (state_r == SBST_SDR);
    if (state_r == SBST_SIR)
      tdo_nxt = ir_sh_r[0];
    else if (sel == SBST_SEL_ID)
      tdo_nxt = id_sh_r[0];
    else if (sel == SBST_SEL_BSR)
      tdo_nxt = bsr_sh_r[0];
    else
      tdo_nxt = byp_r;
  end

  // falling edge gives the far end a half period of setup
  always_ff @(negedge test_clk)
  begin
    if (tck_rst)
    begin
      test_data_out <= 1'b0;
      tdo_oe_r      <= 1'b0;
    end
    else
    begin
      test_data_out <= tdo_nxt;
      tdo_oe_r      <= tdo_oe_nxt;
    end
  end

  assign test_data_out_oe = tdo_oe_r;

  // ==========================================================
  // instruction effects crossing to the memory clock
  logic               extest_lvl;
  logic               samplez_lvl;
  logic               extest_s;
  logic               samplez_s;
  logic [BSR_LEN-1:0] bsr_upd_s;

  assign extest_lvl  = (ir_r == SBST_IR_EXTEST);
  assign samplez_lvl = (ir_r == SBST_IR_SAMPLEZ);

  // update values are static while they cross: they change only at update-dr, update-ir and test-logic-reset
  sbst_sync2 #(.W(BSR_LEN+2)) u_ctl_sync (
    .clk (core_clk),
    .d   ({extest_lvl, samplez_lvl, bsr_upd_r}),
    .q   ({extest_s, samplez_s, bsr_upd_s})
  );

  logic               ring_drive_en_nxt;
  logic               q_bus_hiz_nxt;
  logic [BSR_LEN-2:0] ring_out_nxt;

  always_comb
  begin
    // idcode, bypass and reserved codes leave the memory alone
    ring_drive_en_nxt = extest_s;
    q_bus_hiz_nxt     = samplez_s || (extest_s && !bsr_upd_s[SBST_OE_CELL]);
    ring_out_nxt      = bsr_upd_s[BSR_LEN-2:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ring_drive_en <= 1'b0;
      q_bus_hiz     <= 1'b0;
      ring_out      <= '0;
    end
    else
    begin
      ring_drive_en <= ring_drive_en_nxt;
      q_bus_hiz     <= q_bus_hiz_nxt;
      ring_out      <= ring_out_nxt;
    end
  end

  // ==========================================================
  // checks in the test clock domain
  logic [2:0] tms_hi_cnt_r;

  always_ff @(posedge test_clk)
  begin
    if (tck_rst || !test_mode_sel)
      tms_hi_cnt_r <= 3'h0;
    else if (tms_hi_cnt_r != 3'h7)
      tms_hi_cnt_r <= tms_hi_cnt_r + 3'h1;
  end

  default clocking cb @(posedge test_clk);
  endclocking

  // sys_rst covers the first test clock edges, before the synchroniser has settled
  default disable iff (tck_rst || sys_rst);

  AST_TDO_OE_SHIFT: assert property (
    test_data_out_oe == (state_r == SBST_SIR || state_r == SBST_SDR))
    else $error("serial output enable outside a shift state");

  AST_TDO_IR_LSB: assert property (
    state_r == SBST_SIR && $past(state_r) == SBST_SIR |-> test_data_out == ir_sh_r[0])
    else $error("serial output is not the instruction lsb");

  AST_TMS_FIVE: assert property (
    tms_hi_cnt_r >= 3'h5 |-> state_r == SBST_TLR)
    else $error("five high mode-select edges did not reach reset");

  AST_IR_RESET: assert property (
    state_r == SBST_TLR |=> ir_r == SBST_IR_IDCODE)
    else $error("identification instruction not loaded in reset");

  AST_IR_CAPTURE: assert property (
    state_r == SBST_CIR |=> ir_sh_r[1:0] == 2'h1)
    else $error("capture-ir pattern wrong");

  AST_IR_UPDATE: assert property (
    state_r == SBST_UIR |=> ir_r == $past(ir_sh_r) ##1 ir_r == $past(ir_sh_r, 2) || state_r == SBST_TLR)
    else $error("instruction not taken at update-ir");

  AST_BYP_CLEAR: assert property (
    state_r == SBST_CDR && sel == SBST_SEL_BYP |=> !byp_r)
    else $error("bypass not cleared at capture");

  AST_ID_CAPTURE: assert property (
    state_r == SBST_CDR && ir_r == SBST_IR_IDCODE |=> id_sh_r == ID_CODE)
    else $error("identification code not captured");

  AST_BSR_MSB_IN: assert property (
    state_r == SBST_SDR && sel == SBST_SEL_BSR |=> bsr_sh_r[BSR_LEN-1] == $past(test_data_in))
    else $error("serial input not in boundary msb");

  AST_OE_CELL_RST: assert property (
    state_r == SBST_TLR |=> !bsr_upd_r[SBST_OE_CELL])
    else $error("output-enable cell not preset low");

  AST_RESERVED_BYP: assert property (
    ir_r == 3'h3 || ir_r == 3'h5 || ir_r == 3'h6 |-> sel == SBST_SEL_BYP)
    else $error("reserved code did not select bypass");

  COV_IR_LOAD: cover property (state_r == SBST_SIR ##1 state_r == SBST_E1IR ##1 state_r == SBST_UIR);
  COV_ID_READ: cover property (state_r == SBST_CDR && sel == SBST_SEL_ID ##1 state_r == SBST_SDR);
  COV_EXTEST_OE: cover property (state_r == SBST_UDR && ir_r == SBST_IR_EXTEST && bsr_sh_r[SBST_OE_CELL]);
  COV_TMS_RESET: cover property (tms_hi_cnt_r == 3'h5 && $past(state_r) != SBST_TLR);

endmodule

`default_nettype wire

/* sbst_ctl.sv */
// scan controller model driving the test access port of the memory
// assumes test clock stands low between frames, 30 ns period within them
`timescale 1ns/1ps
`default_nettype none

module sbst_ctl (
  output var  logic test_clk,
  output var  logic test_mode_sel,
  output var  logic test_data_in,
  input  wire logic test_data_out,
  input  wire logic test_data_out_oe
);
  logic tdo_s;
  logic oe_bad;

  initial
  begin
    test_clk      = 1'b0;
    test_mode_sel = 1'b1;
    test_data_in  = 1'b1;
    tdo_s         = 1'b0;
    oe_bad        = 1'b0;
  end

  // ==========================================================
  // one period; inputs move with the fall, output taken at the rise
  task automatic tick(input logic tms, input logic tdi, input logic oe_exp);
    test_mode_sel = tms;
    test_data_in  = tdi;
    #15;
    tdo_s  = test_data_out;
    oe_bad = oe_bad | (test_data_out_oe !== oe_exp);
    test_clk = 1'b1;
    #15;
    test_clk = 1'b0;
  endtask

  // ==========================================================
  // walk into shift-dr first, so the reset starts from a busy state
  task automatic tap_reset();
    tick(1'b1, 1'b0, 1'b0);
    tick(1'b0, 1'b0, 1'b0);
    tick(1'b0, 1'b0, 1'b0);
    repeat (5) tick(1'b1, 1'b0, 1'b0);
    tick(1'b0, 1'b0, 1'b0);
  endtask

  // ==========================================================
  // full scan from idle back to idle; idle ticks let ring values settle
  task automatic scan(input logic ir, input int n, input logic [108:0] din,
                      output logic [108:0] dout, output logic bad);
    dout   = '0;
    oe_bad = 1'b0;
    repeat (2) tick(1'b0, ~din[0], 1'b0);
    tick(1'b1, 1'b0, 1'b0);
    if (ir)
      tick(1'b1, 1'b0, 1'b0);
    tick(1'b0, 1'b0, 1'b0);
    tick(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], 1'b1);
      dout[i] = tdo_s;
    end
    tick(1'b1, 1'b0, 1'b0);
    tick(1'b0, ~din[n-1], 1'b0);
    bad = oe_bad;
  endtask
endmodule

`default_nettype wire

/* tb_sbst_tap.sv */
// self-checking bench for the boundary-scan port, with a reference model
// assumes the controller model drives the test pins; bench owns core side
`timescale 1ns/1ps
`default_nettype none

module tb_sbst_tap;
  import sbst_pkg::*;
  // arbitrary identification value, bit 0 set
  localparam logic [31:0] ID_VAL = 32'h5a3c_0f01;

  logic                    core_clk;
  logic                    sys_rst;
  logic [SBST_BSR_LEN-2:0] ring_in;
  wire  logic [SBST_BSR_LEN-2:0] ring_out;
  wire  logic              test_clk, test_mode_sel, test_data_in;
  wire  logic              test_data_out, test_data_out_oe, ring_drive_en, q_bus_hiz;
  int                      fails;
  int                      compares;
  integer                  seed;
  logic [2:0]              ir_m;
  logic [108:0]            cells_m;
  logic [108:0]            din;
  logic                    pre_ok;
  logic [2:0]              rsv [3] = '{3'h3, 3'h5, 3'h6};

  sbst_tap #(.BSR_LEN(SBST_BSR_LEN), .ID_CODE(ID_VAL)) sbst_tap_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .test_clk(test_clk),
    .test_mode_sel(test_mode_sel), .test_data_in(test_data_in),
    .test_data_out(test_data_out), .test_data_out_oe(test_data_out_oe),
    .ring_in(ring_in), .ring_out(ring_out), .ring_drive_en(ring_drive_en),
    .q_bus_hiz(q_bus_hiz));

  sbst_ctl sbst_ctl_inst (
    .test_clk(test_clk), .test_mode_sel(test_mode_sel), .test_data_in(test_data_in),
    .test_data_out(test_data_out), .test_data_out_oe(test_data_out_oe));

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  // ==========================================================
  // compare and report
  task automatic chk_vec(input string what, input logic [108:0] exp, input logic [108:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic test_end(input string name);
    $display("test %s done, mismatches so far %0d", name, fails);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [108:0] rnd();
    logic [127:0] t;
    t = {$random(seed), $random(seed), $random(seed), $random(seed)};
    return t[108:0];
  endfunction

  // ==========================================================
  // reference model: core outputs are checked five core cycles after the scan
  task automatic core_chk();
    logic ext;
    ext = (ir_m == SBST_IR_EXTEST);
    repeat (5) @(negedge core_clk);
    chk_bit("ring_drive_en", ext, ring_drive_en);
    chk_bit("q_bus_hiz", (ir_m == SBST_IR_SAMPLEZ) || (ext && !cells_m[108]), q_bus_hiz);
    if (ext && pre_ok)
      chk_vec("ring_out", {1'b0, cells_m[107:0]}, {1'b0, ring_out});
  endtask

  task automatic ir_load(input logic [2:0] code);
    logic [108:0] got;
    logic         bad;
    sbst_ctl_inst.scan(1'b1, 3, {106'h0, code}, got, bad);
    chk_vec("ir_capture", {106'h0, SBST_IR_CAPTURE}, {106'h0, got[2:0]});
    chk_bit("oe_window", 1'b0, bad);
    ir_m = code;
    core_chk();
  endtask

  task automatic dr(input int n, input logic [108:0] d);
    logic [108:0] e;
    logic [108:0] got;
    logic [108:0] msk;
    logic         bad;
    logic         bsr;
    msk = ~({109{1'b1}} << n);
    bsr = (ir_m == SBST_IR_EXTEST) || (ir_m == SBST_IR_SAMPLEZ) || (ir_m == SBST_IR_SAMPLE);
    if (ir_m == SBST_IR_IDCODE)
      e = {77'h0, ID_VAL};
    else if (bsr)
      e = {cells_m[108], ring_in};
    else
      e = {d[107:0], 1'b0};
    sbst_ctl_inst.scan(1'b0, n, d, got, bad);
    chk_vec("scan_out", e & msk, got & msk);
    chk_bit("oe_window", 1'b0, bad);
    if (bsr)
    begin
      cells_m = d;
      pre_ok  = 1'b1;
    end
    core_chk();
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    seed    = 32'he258472f;
    fails   = 0;
    compares = 0;
    sys_rst = 1'b1;
    ring_in = '0;
    ir_m    = SBST_IR_IDCODE;
    cells_m = '0;
    pre_ok  = 1'b0;
    repeat (4) sbst_ctl_inst.tick(1'b1, 1'b1, 1'b0);
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (2) sbst_ctl_inst.tick(1'b1, 1'b1, 1'b0);
    sbst_ctl_inst.tick(1'b0, 1'b1, 1'b0);
    chk_bit("oe_after_reset", 1'b0, test_data_out_oe);
    core_chk();
    dr(32, rnd());
    test_end("id_after_reset");
    ir_load(SBST_IR_BYPASS);
    dr(8, rnd());
    test_end("bypass");
    foreach (rsv[k])
    begin
      ir_load(rsv[k]);
      dr(4, rnd());
    end
    test_end("reserved");
    @(negedge core_clk);
    din = rnd();
    ring_in = din[107:0];
    ir_load(SBST_IR_SAMPLE);
    din = rnd() | {1'b1, 108'h0};
    dr(109, din);
    test_end("sample_preload");
    ir_load(SBST_IR_EXTEST);
    @(negedge core_clk);
    din = rnd();
    ring_in = din[107:0];
    dr(109, rnd() & {1'b0, {108{1'b1}}});
    test_end("extest");
    ir_load(SBST_IR_SAMPLEZ);
    dr(109, rnd());
    test_end("sample_z");
    sbst_ctl_inst.tap_reset();
    ir_m = SBST_IR_IDCODE;
    cells_m[108] = SBST_OE_CELL_RST;
    pre_ok = 1'b0;
    core_chk();
    dr(32, rnd());
    ir_load(SBST_IR_EXTEST);
    test_end("tap_reset");
    complete_run();
  end

  initial
  begin
    #1ms;
    fails++;
    complete_run();
  end
endmodule

`default_nettype wire
